// [rtl/lscap_regs.sv]
`timescale 1ns/100ps
`include "lscap_map.svh"

module lscap_regs
    import lscap_pkg::*;
#(
    parameter int            ADDR_W         = 12,
    parameter logic [1:0]    MAX_PREFIX     = 2'h0,
    parameter logic          PREFIX_SUPPORT = 1'b0,
    parameter logic          EXT_FMT        = 1'b0,
    parameter logic [1:0]    OBFF_LEVEL     = 2'h0,
    parameter lscap_tph_type TPH_LEVEL      = LSCAP_TPH_NONE,
    parameter logic          LTR_SUPPORT    = 1'b0,
    parameter logic          CAS128         = 1'b0,
    parameter logic          ATOM64         = 1'b0,
    parameter logic          ATOM32         = 1'b0,
    parameter logic [3:0]    TIMEOUT_RANGES = 4'h0
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata_q,
    output logic                   pready_q,
    output logic                   pslverr_q,
    input  wire logic              slot_clock_strap,
    input  wire logic              link_up,
    input  wire logic [5:0]        trained_width,
    input  wire logic [3:0]        trained_speed,
    input  wire logic              tlp_start,
    input  wire logic              tlp_prefix,
    input  wire logic              tlp_end,
    output logic                   malformed_prefix_q
);

    localparam logic [ADDR_W-1:0] LSR_ADDR  = ADDR_W'(`LSCAP_LSR_ADDR);
    localparam logic [ADDR_W-1:0] DFC2_ADDR = ADDR_W'(`LSCAP_DFC2_ADDR);
    localparam logic [ADDR_W-1:0] PEC_ADDR  = ADDR_W'(`LSCAP_PEC_ADDR);

    // Elaboration checks; no run-time process needed
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("lscap_regs: ADDR_W must lie in 10..32");
    end
    // RQ8 reserved code refused
    if (TPH_LEVEL == `LSCAP_TPH_RESERVED) begin : g_bad_tph
        $error("lscap_regs: processing hint level 10b is reserved");
    end
    if (!PREFIX_SUPPORT && MAX_PREFIX != 2'h0) begin : g_bad_prefix
        $error("lscap_regs: prefix limit set without prefix support");
    end

    lscap_bus_type  bus_q;
    logic           slot_clock_q;
    logic           strap_taken_q;
    logic [5:0]     width_q;
    logic [3:0]     speed_q;
    logic [15:0]    pec_q;
    logic           malformed;
    lscap_word_type lsr_word;
    lscap_word_type dfc2_word;
    lscap_word_type read_word;
    logic           addr_hit;
    logic           setup;
    logic           done;

    assign setup = psel && !penable && (bus_q == LSCAP_BUS_IDLE);
    assign done  = psel && penable && pready_q;

    // RQ1 strap caught after release
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            strap_taken_q <= 1'b0;
            slot_clock_q  <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            slot_clock_q  <= slot_clock_strap;
        end
    end

    // RQ2 trained width tracked
    // RQ3 trained speed tracked
    // Link down reports zero rather than stale training results
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            width_q <= `LSCAP_WIDTH_RESET;
            speed_q <= `LSCAP_SPEED_RESET;
        end else if (link_up) begin
            width_q <= trained_width;
            speed_q <= trained_speed;
        end else begin
            width_q <= `LSCAP_WIDTH_RESET;
            speed_q <= `LSCAP_SPEED_RESET;
        end
    end

    lscap_prefix_check u_prefix_check (
        .mclk           (mclk),
        .nrst           (nrst),
        .max_count      (MAX_PREFIX),
        .prefix_allowed (PREFIX_SUPPORT),
        .tlp_start      (tlp_start),
        .tlp_prefix     (tlp_prefix),
        .tlp_end        (tlp_end),
        .malformed_q    (malformed)
    );

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            malformed_prefix_q <= 1'b0;
        end else begin
            malformed_prefix_q <= malformed;
        end
    end

    // A completed write to the error counter clears; a same-cycle event still counts
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pec_q <= `LSCAP_PEC_RESET;
        end else if (done && pwrite && paddr == PEC_ADDR) begin
            pec_q <= {15'h0000, malformed};
        end else if (malformed && pec_q != 16'hFFFF) begin
            pec_q <= pec_q + 16'h0001;
        end
    end

    // RQ16 reserved bits zero
    always_comb begin
        lsr_word = `LSCAP_WORD_RESET;
        // RQ1 slot clock bit
        lsr_word[`LSCAP_SLOT_CLK_BIT] = slot_clock_q;
        // RQ2 width field
        lsr_word[`LSCAP_WIDTH_MSB:`LSCAP_WIDTH_LSB] = width_q;
        // RQ3 speed field
        lsr_word[`LSCAP_SPEED_MSB:`LSCAP_SPEED_LSB] = speed_q;
    end

    always_comb begin
        dfc2_word = `LSCAP_WORD_RESET;
        // RQ4 prefix limit field
        dfc2_word[`LSCAP_MAXPFX_MSB:`LSCAP_MAXPFX_LSB] = MAX_PREFIX;
        // RQ5 prefix support bit
        dfc2_word[`LSCAP_PFXSUP_BIT] = PREFIX_SUPPORT;
        // RQ6 extended format bit
        dfc2_word[`LSCAP_EXTFMT_BIT] = EXT_FMT;
        // RQ7 flush hint level
        dfc2_word[`LSCAP_OBFF_MSB:`LSCAP_OBFF_LSB] = OBFF_LEVEL;
        // RQ8 completer hint level
        dfc2_word[`LSCAP_TPH_MSB:`LSCAP_TPH_LSB] = TPH_LEVEL;
        // RQ9 latency tolerance bit
        dfc2_word[`LSCAP_LTR_BIT] = LTR_SUPPORT;
        // RQ10 inapplicable bits zero
        dfc2_word[`LSCAP_ROPASS_BIT] = `LSCAP_HARD_ZERO;
        dfc2_word[`LSCAP_AROUTE_BIT] = `LSCAP_HARD_ZERO;
        dfc2_word[`LSCAP_ARIFWD_BIT] = `LSCAP_HARD_ZERO;
        // RQ11 wide CAS bit
        dfc2_word[`LSCAP_CAS128_BIT] = CAS128;
        // RQ12 64-bit atomics bit
        dfc2_word[`LSCAP_ATOM64_BIT] = ATOM64;
        // RQ13 32-bit atomics bit
        dfc2_word[`LSCAP_ATOM32_BIT] = ATOM32;
        // RQ14 timeout disable one
        dfc2_word[`LSCAP_TIMEOUT_DISABLE_SUPPORT_BIT] = `LSCAP_TIMEOUT_DISABLE_SUPPORT_VALUE;
        // RQ15 timeout ranges field
        dfc2_word[`LSCAP_TIMEOUT_RANGES_SUPPORTED_MSB:`LSCAP_TIMEOUT_RANGES_SUPPORTED_LSB] = TIMEOUT_RANGES;
    end

    // RQ16 writes have no effect, except that a write to the error counter clears it
    always_comb begin
        read_word = `LSCAP_WORD_RESET;
        addr_hit  = 1'b1;
        case (paddr)
            LSR_ADDR:  read_word = lsr_word;
            DFC2_ADDR: read_word = dfc2_word;
            PEC_ADDR:  read_word = {16'h0000, pec_q};
            default:   addr_hit  = 1'b0;
        endcase
    end

    // One wait-free answer: pready rises in the first access cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bus_q <= LSCAP_BUS_IDLE;
        end else begin
            case (bus_q)
                LSCAP_BUS_IDLE:   bus_q <= setup ? LSCAP_BUS_ANSWER : LSCAP_BUS_IDLE;
                LSCAP_BUS_ANSWER: bus_q <= done ? LSCAP_BUS_IDLE : LSCAP_BUS_ANSWER;
                default:          bus_q <= LSCAP_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `LSCAP_WORD_RESET;
        end else if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= !addr_hit;
            prdata_q  <= pwrite ? `LSCAP_WORD_RESET : read_word;
        end else if (done || !psel) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `LSCAP_WORD_RESET;
        end
    end

endmodule // lscap_regs

// [rtl/lscap_map.svh]
// What this block does
// RQ1: Slot-clock bit is one on connector reference clock, zero on own clock.
// RQ2: Negotiated-width field shows trained link width; undefined while link down.
// RQ3: Current-speed field shows trained link speed; undefined while link down.
// RQ4: Two-bit field gives prefix limit; TLPs with more prefixes are malformed.
// RQ5: Prefix-support bit is one only when end-to-end prefixes are received.
// RQ6: Extended-format bit one for three-bit format field, zero for two-bit.
// RQ7: Two-bit read-only field reports buffer flush/fill hint support level.
// RQ8: Processing-hint completer level is 00b, 01b or 11b; never 10b.
// RQ9: Latency-tolerance-support bit is one when that mechanism exists.
// RQ10: Relaxed-order passing, atomic routing and alt-routing forwarding read zero.
// RQ11: Wide compare-and-swap completer bit is one exactly when supported.
// RQ12: 64-bit atomic completer bit is one when those operations complete.
// RQ13: 32-bit atomic completer bit is one when those operations complete.
// RQ14: Completion-timeout-disable-support bit always reads one.
// RQ15: Four-bit read-only field lists supported completion-timeout ranges.
// RQ16: Reserved bits read zero; writes to both registers are ignored.
`ifndef LSCAP_MAP_SVH
`define LSCAP_MAP_SVH

// Register indices; byte address is four times the index
`define LSCAP_LSR_INDEX        8'h12
`define LSCAP_DFC2_INDEX       8'h24
`define LSCAP_PEC_INDEX        8'h30
`define LSCAP_LSR_ADDR         {`LSCAP_LSR_INDEX, 2'b00}
`define LSCAP_DFC2_ADDR        {`LSCAP_DFC2_INDEX, 2'b00}
`define LSCAP_PEC_ADDR         {`LSCAP_PEC_INDEX, 2'b00}

// Link state report fields
`define LSCAP_SLOT_CLK_BIT     12
`define LSCAP_WIDTH_MSB        9
`define LSCAP_WIDTH_LSB        4
`define LSCAP_SPEED_MSB        3
`define LSCAP_SPEED_LSB        0

// Device feature caps two fields
`define LSCAP_MAXPFX_MSB       23
`define LSCAP_MAXPFX_LSB       22
`define LSCAP_PFXSUP_BIT       21
`define LSCAP_EXTFMT_BIT       20
`define LSCAP_OBFF_MSB         19
`define LSCAP_OBFF_LSB         18
`define LSCAP_TPH_MSB          13
`define LSCAP_TPH_LSB          12
`define LSCAP_LTR_BIT          11
`define LSCAP_ROPASS_BIT       10
`define LSCAP_CAS128_BIT       9
`define LSCAP_ATOM64_BIT       8
`define LSCAP_ATOM32_BIT       7
`define LSCAP_AROUTE_BIT       6
`define LSCAP_ARIFWD_BIT       5
`define LSCAP_TIMEOUT_DISABLE_SUPPORT_BIT         4
`define LSCAP_TIMEOUT_RANGES_SUPPORTED_MSB         3
`define LSCAP_TIMEOUT_RANGES_SUPPORTED_LSB         0

// Fixed values and reset values
`define LSCAP_HARD_ZERO        1'b0
`define LSCAP_TIMEOUT_DISABLE_SUPPORT_VALUE       1'b1
`define LSCAP_TPH_RESERVED     2'b10
`define LSCAP_WORD_RESET       32'h00000000
`define LSCAP_WIDTH_RESET      6'h00
`define LSCAP_SPEED_RESET      4'h0
`define LSCAP_PEC_RESET        16'h0000

`endif

// [rtl/lscap_pkg.sv]
package lscap_pkg;

    typedef enum logic [1:0] {
        LSCAP_TPH_NONE     = 2'b00,
        LSCAP_TPH_BASIC    = 2'b01,
        LSCAP_TPH_EXTENDED = 2'b11
    } lscap_tph_type;

    typedef enum {
        LSCAP_BUS_IDLE,
        LSCAP_BUS_ANSWER
    } lscap_bus_type;

    typedef logic [31:0] lscap_word_type;

endpackage

// [rtl/lscap_prefix_check.sv]
`timescale 1ns/100ps
`include "lscap_map.svh"

module lscap_prefix_check
    import lscap_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [1:0] max_count,
    input  wire logic       prefix_allowed,
    input  wire logic       tlp_start,
    input  wire logic       tlp_prefix,
    input  wire logic       tlp_end,
    output logic            malformed_q
);

    logic [2:0] count_q;
    logic [2:0] count_d;

    // Saturate so a long prefix run cannot wrap back under the limit
    always_comb begin
        count_d = tlp_start ? 3'h0 : count_q;
        if (tlp_prefix && count_d != 3'h7) begin
            count_d = count_d + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count_q <= 3'h0;
        end else if (tlp_end) begin
            count_q <= 3'h0;
        end else begin
            count_q <= count_d;
        end
    end

    // RQ4 excess prefixes malformed
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            malformed_q <= 1'b0;
        end else begin
            malformed_q <= tlp_end && ((count_d > {1'b0, max_count}) ||
                           (!prefix_allowed && count_d != 3'h0));
        end
    end

endmodule // lscap_prefix_check

// [verification/lscap_regs_assertions.sv]
`timescale 1ns/100ps

module lscap_regs_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata_q,
    input wire logic              pready_q,
    input wire logic              pslverr_q,
    input wire logic              tlp_end,
    input wire logic              malformed_prefix_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic rd_lsr;
    logic rd_dfc2;
    assign rd_lsr  = pready_q && !pwrite && !pslverr_q && paddr == ADDR_W'(12'h048);
    assign rd_dfc2 = pready_q && !pwrite && !pslverr_q && paddr == ADDR_W'(12'h090);

    a_ready_after_setup: assert property (psel && !penable |=> pready_q)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready_q |=> !pready_q)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready_q |-> psel && penable)
        else $error("ready outside access");
    a_idle_data_zero: assert property (!pready_q |-> prdata_q == 32'h00000000)
        else $error("read data outside answer");
    a_error_data_zero: assert property (pslverr_q |-> pready_q && prdata_q == 32'h00000000)
        else $error("error answer carries data");
    a_lsr_reserved_zero: assert property (rd_lsr |-> prdata_q[31:13] == 19'h0 && prdata_q[11:10] == 2'h0)
        else $error("link word reserved bits set");
    a_dfc2_fixed_bits: assert property (rd_dfc2 |-> prdata_q[4] && !prdata_q[10] && !prdata_q[6] && !prdata_q[5])
        else $error("fixed capability bits wrong");
    a_dfc2_reserved_zero: assert property (rd_dfc2 |-> prdata_q[31:24] == 8'h0 && prdata_q[17:14] == 4'h0)
        else $error("capability reserved bits set");
    a_tph_code_legal: assert property (rd_dfc2 |-> prdata_q[13:12] != 2'b10)
        else $error("reserved hint code reported");
    a_malformed_cause: assert property (malformed_prefix_q |-> $past(tlp_end, 2) && !$past(malformed_prefix_q))
        else $error("malformed pulse without end");

    c_read_lsr: cover property (rd_lsr);
    c_read_dfc2: cover property (rd_dfc2);
    c_bus_error: cover property (pslverr_q);
    c_malformed: cover property (malformed_prefix_q);
endmodule // lscap_regs_checker

bind lscap_regs lscap_regs_checker #(.ADDR_W(ADDR_W)) i_checker (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .tlp_end(tlp_end), .malformed_prefix_q(malformed_prefix_q));

// [verification/lscap_regs_bench.sv]
`timescale 1ns/100ps

module lscap_regs_bench;
    import lscap_pkg::*;
    logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata_q, rd;
    logic        pready_q, pslverr_q, er, malformed_prefix_q;
    logic        slot_clock_strap, link_up;
    logic [5:0]  trained_width;
    logic [3:0]  trained_speed;
    logic        tlp_start = 1'b0, tlp_prefix = 1'b0, tlp_end = 1'b0;
    int          bad_count = 0, checks_done = 0, cycles = 0, pulses = 0;

    lscap_regs #(.MAX_PREFIX(2'h1), .PREFIX_SUPPORT(1'b1), .EXT_FMT(1'b1), .OBFF_LEVEL(2'h2),
        .TPH_LEVEL(LSCAP_TPH_EXTENDED), .LTR_SUPPORT(1'b1), .ATOM64(1'b1), .ATOM32(1'b1),
        .TIMEOUT_RANGES(4'hA)) i_dut (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .slot_clock_strap(slot_clock_strap), .link_up(link_up),
        .trained_width(trained_width), .trained_speed(trained_speed), .tlp_start(tlp_start),
        .tlp_prefix(tlp_prefix), .tlp_end(tlp_end), .malformed_prefix_q(malformed_prefix_q));

    always #20 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (malformed_prefix_q === 1'b1) pulses++;
        // Hang guard, run needs under a hundred cycles
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Link state as training would leave it
    task automatic link(input logic up, input logic [5:0] w, input logic [3:0] s);
        link_up <= up;
        trained_width <= w;
        trained_speed <= s;
    endtask

    // Ten reset cycles; strap is caught just after release
    task automatic restart(input logic strap);
        nrst <= 1'b0;
        slot_clock_strap <= strap;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
    endtask

    // A wait for ready has no limit; only the hang guard ends one that hangs
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // One TLP of n prefixes, n at least one
    task automatic tlp(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            tlp_start <= (i == 0); tlp_prefix <= 1'b1; tlp_end <= (i == n - 1);
        end
        @(posedge mclk);
        tlp_start <= 1'b0; tlp_prefix <= 1'b0; tlp_end <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        link(1'b1, 6'h08, 4'h3);
        restart(1'b1);
        apb(1'b0, 12'h048, 32'h0);
        check(rd, 32'h00001083);
        check({31'h0, er}, 32'h0);
        apb(1'b0, 12'h090, 32'h0);
        check(rd, 32'h0078399A);
        // Writes must leave both words untouched
        apb(1'b1, 12'h090, 32'hFFFFFFFF);
        check({31'h0, er}, 32'h0);
        apb(1'b0, 12'h090, 32'h0);
        check(rd, 32'h0078399A);
        apb(1'b1, 12'h048, 32'hFFFFFFFF);
        apb(1'b0, 12'h048, 32'h0);
        check(rd, 32'h00001083);
        apb(1'b0, 12'h100, 32'h0);
        check({31'h0, er}, 32'h1);
        // Width and speed read zero while link down
        link(1'b0, 6'h08, 4'h3);
        apb(1'b0, 12'h048, 32'h0);
        check(rd, 32'h00001000);
        tlp(1);
        check(pulses, 32'h0);
        tlp(2);
        check(pulses, 32'h1);
        apb(1'b0, 12'h0C0, 32'h0);
        check(rd, 32'h00000001);
        // Second reset: own clock, new training, count back to zero
        link(1'b1, 6'h04, 4'h1);
        restart(1'b0);
        apb(1'b0, 12'h048, 32'h0);
        check(rd, 32'h00000041);
        apb(1'b0, 12'h0C0, 32'h0);
        check(rd, 32'h00000000);
        tlp(3);
        check(pulses, 32'h2);
        apb(1'b0, 12'h0C0, 32'h0);
        check(rd, 32'h00000001);
        apb(1'b1, 12'h0C0, 32'h0);
        apb(1'b0, 12'h0C0, 32'h0);
        check(rd, 32'h00000000);
        final_report();
    end
endmodule // lscap_regs_bench
